// ===== tb/pcd_pins_model.sv
// Board side of the pins: outside drivers and a slave port host.
`timescale 1ns/1ns
`default_nettype none
module pcd_pins_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] c_drv_i, c_oe_i, d_drv_i, d_oe_i, ext_c_i, ext_d_i,
  output wire logic [7:0] c_pin_o, d_pin_o,
  output var  logic       cs_n_o = 1'b1,
  output var  logic       rd_n_o = 1'b1,
  output var  logic       wr_n_o = 1'b1
);
  logic [7:0] host_d = 8'h00;  // Byte the host puts on port D.
  logic       host_drv = 1'b0; // High while the host drives port D.
  // Each wire shows whoever drives it, else the outside level.
  assign c_pin_o = (c_oe_i & c_drv_i) | (~c_oe_i & ext_c_i);
  assign d_pin_o = (d_oe_i & d_drv_i) |
                   (~d_oe_i & (host_drv ? host_d : ext_d_i));
  // Host read: select and read low, byte taken while still held.
  task automatic host_read(output logic [7:0] b);
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (6) @(posedge clock_i);
    b = d_pin_o;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (6) @(posedge clock_i);
  endtask
  // Host write: data stays put one cycle past the strobes.
  task automatic host_write(input logic [7:0] b);
    @(posedge clock_i);
    host_d <= b;
    host_drv <= 1'b1;
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    repeat (6) @(posedge clock_i);
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    @(posedge clock_i);
    host_drv <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask
endmodule // pcd_pins_model
`default_nettype wire

// ===== tb/pcd_ports_bench.sv
// Self-checking bench of the port C and port D block.
`timescale 1ns/1ns
`default_nettype none
module pcd_ports_bench;
  logic clock_i = 0, rst_i = 1, other_rst_i = 0, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 0, wdata_i = 0, ext_c = 0, ext_d = 0, lat, dir, got;
  logic [2:0] status = 0;  // Buffer flags shown in the control register.
  logic [21:0] per = 0;    // Peripheral claims, idle until the last phase.
  logic rd_seen = 0, p;
  wire [7:0] rdata_o, c_o, c_oe, d_o, d_oe, c_pin, d_pin;
  wire cs_n, rd_n, wr_n, rd_done, wr_done;  // Strobes and end pulses.
  wire [7:0] c_in;                          // Synchronised port C levels.
  logic [7:0] exp_q[$];    // Expected read data, oldest first.
  int n_fail = 0, n_checks = 0, cyc = 0;
  int n_rd_done = 0, n_wr_done = 0;  // Host strobe end pulses seen.
  pcd_ports u_dut (.clock_i, .rst_i, .other_rst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .port_c_pin_i(c_pin), .port_c_pin_o(c_o),
    .port_c_pin_oe_o(c_oe), .port_d_pin_i(d_pin), .port_d_pin_o(d_o),
    .port_d_pin_oe_o(d_oe), .slave_cs_n_i(cs_n), .slave_rd_n_i(rd_n),
    .slave_wr_n_i(wr_n), .slave_status_i(status),
    .slave_port_mode_select_o(), .port_e_direction_o(),
    .slave_rd_done_o(rd_done), .slave_wr_done_o(wr_done), .port_c_in_o(c_in),
    .tmr_osc_en_i(per[0]), .secondary_timer_osc_out_i(per[1]),
    .tmr_ext_clk_en_i(per[2]), .ccp_one_en_i(per[3]), .ccp_one_out_i(per[4]),
    .ccp_one_oe_i(per[5]), .ccp_two_en_i(per[6]), .ccp_two_out_i(per[7]),
    .ccp_two_oe_i(per[8]), .ssp_en_i(per[9]), .ssp_i2c_i(per[10]),
    .ssp_clk_out_i(per[11]), .ssp_clk_oe_i(per[12]), .ssp_sdo_i(per[13]),
    .ssp_sda_low_i(per[14]), .usart_en_i(per[15]), .usart_sync_i(per[16]),
    .usart_tx_i(per[17]), .usart_sync_clock_line_out_i(per[18]),
    .usart_sync_clock_line_oe_i(per[19]),
    .usart_sync_data_line_out_i(per[20]),
    .usart_sync_data_line_oe_i(per[21]));
  pcd_pins_model u_host (.clock_i, .c_drv_i(c_o), .c_oe_i(c_oe),
    .d_drv_i(d_o), .d_oe_i(d_oe), .ext_c_i(ext_c), .ext_d_i(ext_d),
    .c_pin_o(c_pin), .d_pin_o(d_pin), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // A read notes its expected byte; the watcher below compares it.
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe.
  always @(posedge clock_i) begin
    rd_seen <= rd_i;
    if (rd_seen) check(rdata_o, exp_q.pop_front(), "rdata");
  end
  // Count the one-cycle strobe end pulses while they stand.
  always @(posedge clock_i) begin
    n_rd_done <= n_rd_done + rd_done;
    n_wr_done <= n_wr_done + wr_done;
  end
  // Cut a hang short.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial forever #25 clock_i = ~clock_i;
  initial begin
    void'($urandom(32'h57d9f572));
    status = 3'($urandom);
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(8'h87, 8'hff);
    rd(8'h88, 8'hff);
    rd(8'h55, 8'h00);
    rd(8'h89, {status, 5'h07});
    wr(8'h89, 8'hff);
    rd(8'h89, {status, 5'h17});
    wr(8'h89, 8'h0a);
    rd(8'h89, {status, 5'h02});
    // Latch, direction and pin readback on both ports.
    for (int i = 0; i < 8; i++) begin
      p = (i % 2 == 1);
      lat = 8'($urandom);
      dir = 8'($urandom);
      ext_c <= 8'($urandom);
      ext_d <= 8'($urandom);
      wr(p ? 8'h08 : 8'h07, lat);
      wr(p ? 8'h88 : 8'h87, dir);
      repeat (3) @(posedge clock_i);
      #1 check(p ? d_oe : c_oe, ~dir, "enable");
      check((p ? d_o : c_o) & ~dir, lat & ~dir, "drive");
      rd(p ? 8'h08 : 8'h07, (lat & ~dir) | ((p ? ext_d : ext_c) & dir));
      #1 if (!p) check(c_in, (lat & ~dir) | (ext_c & dir), "sync in");
    end
    // A latch survives the other reset; direction returns to input.
    wr(8'h07, 8'h5a);
    @(posedge clock_i);
    other_rst_i <= 1'b1;
    @(posedge clock_i);
    other_rst_i <= 1'b0;
    rd(8'h87, 8'hff);
    wr(8'h87, 8'h00);
    repeat (3) @(posedge clock_i);
    #1 check(c_o, 8'h5a, "kept latch");
    // Slave port: direction ignored, host reads latch, writes a byte.
    wr(8'h08, lat);
    wr(8'h89, 8'h17);
    wr(8'h88, 8'h00);
    repeat (3) @(posedge clock_i);
    #1 check(d_oe, 8'h00, "slave idle");
    u_host.host_read(got);
    check(got, lat, "host read");
    u_host.host_write(~lat);
    rd(8'h08, ~lat);
    check(8'(n_rd_done), 8'h01, "read end");
    check(8'(n_wr_done), 8'h01, "write end");
    wr(8'h89, 8'h07);
    // Random peripheral claims for the pin sharing checks.
    repeat (300) @(posedge clock_i) per <= 22'($urandom);
    repeat (2) @(posedge clock_i);
    tally_and_finish();
  end
endmodule // pcd_ports_bench
bind pcd_ports pcd_ports_monitor u_mon (.clock_i, .rst_i, .other_rst_i,
  .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .port_c_pin_o, .port_c_pin_oe_o,
  .port_d_pin_oe_o, .slave_cs_n_i, .slave_rd_n_i, .slave_port_mode_select_o,
  .tmr_osc_en_i, .secondary_timer_osc_out_i, .ccp_one_en_i, .ccp_one_out_i,
  .ccp_one_oe_i, .ssp_en_i, .ssp_i2c_i, .ssp_clk_out_i, .ssp_clk_oe_i,
  .ssp_sdo_i, .ssp_sda_low_i, .usart_en_i, .usart_sync_i, .usart_tx_i,
  .ccp_two_en_i, .ccp_two_out_i, .ccp_two_oe_i, .tmr_ext_clk_en_i,
  .usart_sync_clock_line_out_i, .usart_sync_clock_line_oe_i,
  .usart_sync_data_line_out_i, .usart_sync_data_line_oe_i,
  .port_e_direction_o);
`default_nettype wire

// ===== tb/pcd_ports_monitor.sv
// Checker of port timing for the port C and port D block.
`timescale 1ns/1ns
`default_nettype none
module pcd_ports_monitor (
  input wire logic       clock_i, rst_i, other_rst_i, wr_i, rd_i,
  input wire logic [7:0] addr_i, wdata_i, rdata_o, port_c_pin_o,
  input wire logic [7:0] port_c_pin_oe_o, port_d_pin_oe_o,
  input wire logic       slave_cs_n_i, slave_rd_n_i, slave_port_mode_select_o,
  input wire logic       tmr_osc_en_i, secondary_timer_osc_out_i,
  input wire logic       ccp_one_en_i, ccp_one_out_i, ccp_one_oe_i,
  input wire logic       ssp_en_i, ssp_i2c_i, ssp_clk_out_i, ssp_clk_oe_i,
  input wire logic       ssp_sdo_i, ssp_sda_low_i,
  input wire logic       usart_en_i, usart_sync_i, usart_tx_i,
  input wire logic       ccp_two_en_i, ccp_two_out_i, ccp_two_oe_i,
  input wire logic       tmr_ext_clk_en_i, usart_sync_clock_line_out_i,
  input wire logic       usart_sync_clock_line_oe_i,
  input wire logic       usart_sync_data_line_out_i, usart_sync_data_line_oe_i,
  input wire logic [2:0] port_e_direction_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i || other_rst_i);
  // One cycle of a host read held in slave mode.
  sequence s_host_rd;
    slave_port_mode_select_o && !slave_cs_n_i && !slave_rd_n_i;
  endsequence
  // A direction write in general mode with no write behind it.
  sequence s_dir_d;
    wr_i && addr_i == 8'h88 && !slave_port_mode_select_o ##1
      !wr_i && !slave_port_mode_select_o;
  endsequence
  property p_rd_zero; !rd_i |=> rdata_o == 8'h00; endproperty
  property p_bit3; rd_i && addr_i == 8'h89 |=> !rdata_o[3]; endproperty
  property p_mode;
    wr_i && addr_i == 8'h89 |=> slave_port_mode_select_o == $past(wdata_i[4])
      && port_e_direction_o == $past(wdata_i[2:0]);
  endproperty
  property p_dir_d; s_dir_d |=> port_d_pin_oe_o == ~$past(wdata_i, 2);
  endproperty
  property p_slave_rd; s_host_rd [*5] |-> port_d_pin_oe_o == 8'hff;
  endproperty
  property p_ccp; ccp_one_en_i |=> port_c_pin_o[2] == $past(ccp_one_out_i)
    && port_c_pin_oe_o[2] == $past(ccp_one_oe_i); endproperty
  property p_spi; ssp_en_i && !ssp_i2c_i |=>
    port_c_pin_o[5] == $past(ssp_sdo_i)
    && port_c_pin_o[3] == $past(ssp_clk_out_i)
    && port_c_pin_oe_o[3] == $past(ssp_clk_oe_i); endproperty
  property p_i2c; ssp_en_i && ssp_i2c_i |=> !port_c_pin_o[4]
    && port_c_pin_oe_o[4] == $past(ssp_sda_low_i); endproperty
  property p_usart; usart_en_i && !usart_sync_i |=> !port_c_pin_oe_o[7]
    && port_c_pin_o[6] == $past(usart_tx_i); endproperty
  property p_osc; tmr_osc_en_i |=> !port_c_pin_oe_o[1]
    && port_c_pin_o[0] == $past(secondary_timer_osc_out_i); endproperty
  // Unit two owns pin 1 only while the oscillator leaves it free.
  property p_two; ccp_two_en_i && !tmr_osc_en_i |=>
    port_c_pin_o[1] == $past(ccp_two_out_i)
    && port_c_pin_oe_o[1] == $past(ccp_two_oe_i); endproperty
  // An external timer clock makes pin 0 an input while the oscillator is off.
  property p_ext; tmr_ext_clk_en_i && !tmr_osc_en_i |=> !port_c_pin_oe_o[0];
  endproperty
  // Synchronous USART drives both its pins from its own enables.
  property p_sync; usart_en_i && usart_sync_i |=>
    port_c_pin_o[6] == $past(usart_sync_clock_line_out_i)
    && port_c_pin_oe_o[6] == $past(usart_sync_clock_line_oe_i)
    && port_c_pin_o[7] == $past(usart_sync_data_line_out_i)
    && port_c_pin_oe_o[7] == $past(usart_sync_data_line_oe_i); endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("rdata not idle");
  a_bit3: assert property (p_bit3) else $error("control bit 3 set");
  a_mode: assert property (p_mode) else $error("mode bit wrong");
  a_dir_d: assert property (p_dir_d) else $error("port D enable wrong");
  a_slave_rd: assert property (p_slave_rd) else $error("no read drive");
  a_ccp: assert property (p_ccp) else $error("pin 2 not unit one");
  a_spi: assert property (p_spi) else $error("serial pins wrong");
  a_i2c: assert property (p_i2c) else $error("data line wrong");
  a_usart: assert property (p_usart) else $error("usart pins wrong");
  a_osc: assert property (p_osc) else $error("oscillator pins wrong");
  a_two: assert property (p_two) else $error("pin 1 not unit two");
  a_ext: assert property (p_ext) else $error("clock pin driven");
  a_sync: assert property (p_sync) else $error("usart sync pins wrong");
endmodule // pcd_ports_monitor
`default_nettype wire

// ===== verilog/pcd_defs.vh
// Constants for the port C and port D block: offsets, fields, resets.
`ifndef PCD_DEFS_VH
`define PCD_DEFS_VH

// Register offsets on the register port.
`define PCD_ADDR_W          8
`define PCD_OFF_PORT_C_DATA 8'h07
`define PCD_OFF_PORT_D_DATA 8'h08
`define PCD_OFF_PORT_C_DIR  8'h87
`define PCD_OFF_PORT_D_DIR  8'h88
`define PCD_OFF_PORT_E_CTL  8'h89

// Reset values of the direction, control and pin drive registers.
`define PCD_RST_PORT_C_DIR  8'hff
`define PCD_RST_PORT_D_DIR  8'hff
`define PCD_RST_PORT_E_DIR  3'h7
`define PCD_RST_MODE        1'h0
`define PCD_RST_PIN_OUT     8'h00

// Fields of the port E control and direction register.
`define PCD_E_STAT_HI       7
`define PCD_E_STAT_LO       5
`define PCD_E_MODE_BIT      4
`define PCD_E_UNUSED_BIT    3
`define PCD_E_DIR_HI        2
`define PCD_E_DIR_LO        0

// Bit positions of the synchronised slave port strobes.
`define PCD_STB_RD          0
`define PCD_STB_WR          1
`define PCD_STB_CS          2

// Answer on an unmapped read.
`define PCD_RD_NONE         8'h00

`endif

// ===== verilog/pcd_ports.v
// Port C and port D pin logic with the slave port mode select.
//
// Contract
// R01: Port D pins each have own direction.
// R02: Mode bit turns port D into slave port.
// R03: Pin n is slave data bit n.
// R04: Data latches keep value over all resets.
// R05: Control bit 3 reads zero, ignores writes.
// R06: Port C pin 0 timer oscillator out/clock.
// R07: Port C pin 1 timer osc in, unit two.
// R08: Port C pin 2 serves unit one.
// R09: Port C pin 3 carries serial port clock.
// R10: Port C pin 4 serial in or I2C data.
// R11: Port C pin 5 carries serial data out.
// R12: Port C pin 6 USART transmit or clock.
// R13: Port C pin 7 USART receive or data.
// R14: Peripheral select picks source; enable when selected.
// R15: Software sets port E pins as inputs first.
// R16: Host reads with select and read low.
// R17: Host writes with select and write low.
// R18: Write sets latch, read gives pins.
// R19: Unclaimed output pin drives its latch.
//
// The strobed register port was chosen for this implementation.
`include "pcd_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module pcd_ports (
  input  wire       clock_i,            // Core clock, 20 MHz.
  input  wire       rst_i,              // Power-on or brown-out reset.
  input  wire       other_rst_i,        // Any other reset source.
  // Register port.
  input  wire [7:0] addr_i,             // Register offset.
  input  wire [7:0] wdata_i,            // Write data.
  input  wire       wr_i,               // Write strobe.
  input  wire       rd_i,               // Read strobe.
  output reg  [7:0] rdata_o,            // Read data, cycle after rd_i.
  // Port C and port D pins.
  input  wire [7:0] port_c_pin_i,       // Port C pin levels.
  output reg  [7:0] port_c_pin_o,       // Port C drive values.
  output reg  [7:0] port_c_pin_oe_o,    // Port C drive enables.
  input  wire [7:0] port_d_pin_i,       // Port D pin levels.
  output reg  [7:0] port_d_pin_o,       // Port D drive values.
  output reg  [7:0] port_d_pin_oe_o,    // Port D drive enables.
  // Slave port strobes, active low, from port E pins.
  input  wire       slave_cs_n_i,       // Chip select.
  input  wire       slave_rd_n_i,       // Read strobe.
  input  wire       slave_wr_n_i,       // Write strobe.
  input  wire [2:0] slave_status_i,     // Buffer flags from slave logic.
  output reg        slave_port_mode_select_o, // Slave port mode bit.
  output reg  [2:0] port_e_direction_o, // Port E direction bits.
  output reg        slave_rd_done_o,    // Pulse: host read ended.
  output reg        slave_wr_done_o,    // Pulse: host write ended.
  output reg  [7:0] port_c_in_o,        // Synchronised port C levels.
  // Peripheral claims on port C.
  input  wire       tmr_osc_en_i,       // Timer oscillator enabled.
  input  wire       secondary_timer_osc_out_i, // Oscillator drive.
  input  wire       tmr_ext_clk_en_i,   // External timer clock used.
  input  wire       ccp_one_en_i,       // Unit one claims its pin.
  input  wire       ccp_one_out_i,      // Unit one output value.
  input  wire       ccp_one_oe_i,       // Unit one drives its pin.
  input  wire       ccp_two_en_i,       // Unit two claims its pin.
  input  wire       ccp_two_out_i,      // Unit two output value.
  input  wire       ccp_two_oe_i,       // Unit two drives its pin.
  input  wire       ssp_en_i,           // Serial port enabled.
  input  wire       ssp_i2c_i,          // Serial port in I2C mode.
  input  wire       ssp_clk_out_i,      // Serial clock value.
  input  wire       ssp_clk_oe_i,       // Serial clock drive.
  input  wire       ssp_sdo_i,          // SPI data out value.
  input  wire       ssp_sda_low_i,      // I2C data pulled low.
  input  wire       usart_en_i,         // USART enabled.
  input  wire       usart_sync_i,       // USART in synchronous mode.
  input  wire       usart_tx_i,         // Asynchronous transmit value.
  input  wire       usart_sync_clock_line_out_i, // Sync clock value.
  input  wire       usart_sync_clock_line_oe_i,  // Sync clock drive.
  input  wire       usart_sync_data_line_out_i,  // Sync data value.
  input  wire       usart_sync_data_line_oe_i    // Sync data drive.
);

  ////////////////////////////////////////////////////////////////////////
  // Storage.

  reg  [7:0] port_c_latch;     // Port C output latch, never reset.
  reg  [7:0] port_d_latch;     // Port D output latch, never reset.
  reg  [7:0] port_c_direction; // One makes a pin an input.
  reg  [7:0] port_d_direction; // One makes a pin an input.
  reg  [7:0] slave_in_byte;    // Byte written by the host.
  reg  [2:0] strobe_last;      // Strobes one cycle earlier.
  reg  [7:0] next_rdata;       // Read data to register.
  reg  [7:0] next_c_out;       // Port C drive values.
  reg  [7:0] next_c_oe;        // Port C drive enables.
  reg  [7:0] next_c_sel;       // Port C peripheral selects.
  reg  [7:0] next_c_po;        // Port C peripheral values.
  reg  [7:0] next_c_poe;       // Port C peripheral enables.
  wire [7:0] port_c_sync;      // Port C levels after two flops.
  wire [7:0] port_d_sync;      // Port D levels after two flops.
  wire [2:0] strobe_sync;      // Strobes after two flops.
  wire       any_rst;          // Either reset source.
  wire       host_rd;          // Host read in progress.
  wire       host_wr;          // Host write in progress.
  wire       was_rd;           // Host read one cycle earlier.
  wire       was_wr;           // Host write one cycle earlier.

  // True when a strobe and a chip select, both active low, are low.
  function strobe_on;
    input [2:0] stb;
    input       bit_sel;
    begin
      strobe_on = ~stb[`PCD_STB_CS] & ~bit_sel;
    end
  endfunction

  // True when the register port hits a given offset.
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  assign any_rst = rst_i | other_rst_i;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for every level that comes from a pin.

  pcd_sync #(.WIDTH(8)) u_sync_c (
    .clock_i (clock_i),
    .async_i (port_c_pin_i),
    .sync_o  (port_c_sync)
  );

  pcd_sync #(.WIDTH(8)) u_sync_d (
    .clock_i (clock_i),
    .async_i (port_d_pin_i),
    .sync_o  (port_d_sync)
  );

  pcd_sync #(.WIDTH(3)) u_sync_stb (
    .clock_i (clock_i),
    .async_i ({slave_cs_n_i, slave_wr_n_i, slave_rd_n_i}),
    .sync_o  (strobe_sync)
  );

  // Host strobes only count in slave port mode.
  assign host_rd = slave_port_mode_select_o &
                   strobe_on(strobe_sync, strobe_sync[`PCD_STB_RD]); // R16
  assign host_wr = slave_port_mode_select_o &
                   strobe_on(strobe_sync, strobe_sync[`PCD_STB_WR]); // R17
  assign was_rd  = strobe_on(strobe_last, strobe_last[`PCD_STB_RD]);
  assign was_wr  = strobe_on(strobe_last, strobe_last[`PCD_STB_WR]);

  ////////////////////////////////////////////////////////////////////////
  // Output latches: written by software, untouched by any reset.

  always @(posedge clock_i) begin
    if (wr_i && hit(addr_i, `PCD_OFF_PORT_C_DATA)) begin
      port_c_latch <= wdata_i; // R18 R04
    end
    if (wr_i && hit(addr_i, `PCD_OFF_PORT_D_DATA)) begin
      port_d_latch <= wdata_i; // R18 R04
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Direction and control registers, set by every reset source.

  always @(posedge clock_i) begin
    if (any_rst) begin
      port_c_direction         <= `PCD_RST_PORT_C_DIR;
      port_d_direction         <= `PCD_RST_PORT_D_DIR;
      port_e_direction_o       <= `PCD_RST_PORT_E_DIR;
      slave_port_mode_select_o <= `PCD_RST_MODE;
    end else if (wr_i) begin
      if (hit(addr_i, `PCD_OFF_PORT_C_DIR)) begin
        port_c_direction <= wdata_i;
      end
      if (hit(addr_i, `PCD_OFF_PORT_D_DIR)) begin
        port_d_direction <= wdata_i; // R01
      end
      // Status bits and bit 3 are not writable here.
      if (hit(addr_i, `PCD_OFF_PORT_E_CTL)) begin
        slave_port_mode_select_o <= wdata_i[`PCD_E_MODE_BIT]; // R02
        port_e_direction_o <=
          wdata_i[`PCD_E_DIR_HI:`PCD_E_DIR_LO]; // R05 R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave port: capture the host byte and flag strobe ends.

  always @(posedge clock_i) begin
    if (any_rst) begin
      strobe_last     <= 3'h7;
      slave_rd_done_o <= 1'b0;
      slave_wr_done_o <= 1'b0;
      slave_in_byte   <= 8'h00;
    end else begin
      strobe_last     <= strobe_sync;
      // A pulse marks the cycle after the synchronised strobe pair went inactive.
      slave_rd_done_o <= slave_port_mode_select_o & was_rd & ~host_rd;
      slave_wr_done_o <= slave_port_mode_select_o & was_wr & ~host_wr;
      // The byte follows the pins while the host write is held.
      if (host_wr) begin
        slave_in_byte <= port_d_sync; // R03 R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port C peripheral claims, one pin at a time.

  always @* begin
    next_c_sel = 8'h00;
    next_c_po  = 8'h00;
    next_c_poe = 8'h00;
    // Pin 0: oscillator drive or external timer clock input.
    if (tmr_osc_en_i) begin
      next_c_sel[0] = 1'b1; // R06
      next_c_po[0]  = secondary_timer_osc_out_i;
      next_c_poe[0] = 1'b1;
    end else if (tmr_ext_clk_en_i) begin
      next_c_sel[0] = 1'b1; // R06
    end
    // Pin 1: oscillator input, else unit two.
    if (tmr_osc_en_i) begin
      next_c_sel[1] = 1'b1; // R07
    end else if (ccp_two_en_i) begin
      next_c_sel[1] = 1'b1; // R07
      next_c_po[1]  = ccp_two_out_i;
      next_c_poe[1] = ccp_two_oe_i;
    end
    // Pin 2: unit one.
    if (ccp_one_en_i) begin
      next_c_sel[2] = 1'b1; // R08
      next_c_po[2]  = ccp_one_out_i;
      next_c_poe[2] = ccp_one_oe_i;
    end
    // Pins 3 to 5: synchronous serial port.
    if (ssp_en_i) begin
      next_c_sel[3] = 1'b1; // R09
      next_c_po[3]  = ssp_clk_out_i;
      next_c_poe[3] = ssp_clk_oe_i;
      next_c_sel[4] = 1'b1; // R10
      if (ssp_i2c_i) begin
        // Open-drain data line: only ever pulled low.
        next_c_po[4]  = 1'b0; // R10
        next_c_poe[4] = ssp_sda_low_i;
      end else begin
        next_c_sel[5] = 1'b1; // R11
        next_c_po[5]  = ssp_sdo_i;
        next_c_poe[5] = 1'b1;
      end
    end
    // Pins 6 and 7: USART.
    if (usart_en_i) begin
      next_c_sel[6] = 1'b1; // R12
      next_c_sel[7] = 1'b1; // R13
      if (usart_sync_i) begin
        next_c_po[6]  = usart_sync_clock_line_out_i; // R12
        next_c_poe[6] = usart_sync_clock_line_oe_i;
        next_c_po[7]  = usart_sync_data_line_out_i; // R13
        next_c_poe[7] = usart_sync_data_line_oe_i;
      end else begin
        next_c_po[6]  = usart_tx_i; // R12
        next_c_poe[6] = 1'b1;
      end
    end
  end

  // Select picks the source; peripheral enable counts only when selected.
  always @* begin
    next_c_out = (next_c_sel & next_c_po) |
                 (~next_c_sel & port_c_latch); // R14 R19
    next_c_oe  = (next_c_sel & next_c_poe) |
                 (~next_c_sel & ~port_c_direction); // R14 R19
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered.

  always @(posedge clock_i) begin
    if (any_rst) begin
      port_c_pin_o    <= `PCD_RST_PIN_OUT;
      port_c_pin_oe_o <= 8'h00;
      port_d_pin_o    <= `PCD_RST_PIN_OUT;
      port_d_pin_oe_o <= 8'h00;
      port_c_in_o     <= 8'h00;
    end else begin
      port_c_pin_o    <= next_c_out;
      port_c_pin_oe_o <= next_c_oe;
      port_c_in_o     <= port_c_sync;
      port_d_pin_o    <= port_d_latch; // R03 R19
      if (slave_port_mode_select_o) begin
        // The host sees the latch only while it reads.
        port_d_pin_oe_o <= {8{host_rd}}; // R02 R16
      end else begin
        port_d_pin_oe_o <= ~port_d_direction; // R01 R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads.

  always @* begin
    case (addr_i)
      `PCD_OFF_PORT_C_DATA: next_rdata = port_c_sync; // R18
      `PCD_OFF_PORT_D_DATA: begin
        if (slave_port_mode_select_o) begin
          next_rdata = slave_in_byte; // R02
        end else begin
          next_rdata = port_d_sync; // R18
        end
      end
      `PCD_OFF_PORT_C_DIR: next_rdata = port_c_direction;
      `PCD_OFF_PORT_D_DIR: next_rdata = port_d_direction;
      `PCD_OFF_PORT_E_CTL: next_rdata = {slave_status_i,
                                         slave_port_mode_select_o,
                                         1'b0, // R05
                                         port_e_direction_o};
      default: next_rdata = `PCD_RD_NONE;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge clock_i) begin
    if (any_rst) begin
      rdata_o <= `PCD_RD_NONE;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `PCD_RD_NONE;
    end
  end

endmodule // pcd_ports

`default_nettype wire

// ===== verilog/pcd_sync.v
// Two flip-flop synchroniser for pin levels entering the core clock.
`timescale 1ns/1ns
`default_nettype none

module pcd_sync #(
  parameter WIDTH = 8
) (
  input  wire             clock_i,  // Core clock.
  input  wire [WIDTH-1:0] async_i,  // Levels from outside the domain.
  output wire [WIDTH-1:0] sync_o    // Levels after two flip-flops.
);

  reg [WIDTH-1:0] stage_one;  // First stage, read only by the second.
  reg [WIDTH-1:0] stage_two;  // Second stage, safe for logic.

  // Both stages run free; no reset is needed for a pure delay line.
  always @(posedge clock_i) begin
    stage_one <= async_i;
    stage_two <= stage_one;
  end

  assign sync_o = stage_two;

endmodule // pcd_sync

`default_nettype wire
